// ===== rtl/plc_aspm_decode.sv
`timescale 1ns/1ps
module plc_aspm_decode
  import plc_pkg::*;
(
  input wire logic [1:0] aspm_i,
  output logic l0s_allowed_o,
  output logic l1_allowed_o
);

  always_comb begin
    l0s_allowed_o = 1'b0;
    l1_allowed_o = 1'b0;
    case (aspm_i)
      PLC_ASPM_DISABLED: begin
        l0s_allowed_o = 1'b0;
      end
      PLC_ASPM_L0S: begin
        l0s_allowed_o = 1'b1;
      end
      PLC_ASPM_L0S_L1: begin
        l0s_allowed_o = 1'b1;
        l1_allowed_o = 1'b1;
      end
      default: begin
        l0s_allowed_o = 1'b0;
      end
    endcase
  end

endmodule

// ===== rtl/plc_link_control.sv
`timescale 1ns/1ps
// Function
// - Whole register resets to zero.
// - Clock request held low while clock power management enable is zero.
// - With enable set, port may power manage link clock via clock request.
// - Without clock PM capability, the enable bit is hardwired zero.
// - Extended sync bit is read-write and selects extra ordered sets.
// - Common clock bit selects reported L0s exit latency and FTS count.
// - Retrain link bit always reads zero.
// - Writing one to retrain starts retraining and self-clears.
// - Link disable reads back last written value immediately.
// - While link disable is one, training goes to Disabled via Recovery.
// - A zero-to-one link disable transition triggers automatic retraining.
// - Read completion boundary bit is read-only zero, 64 bytes.
// - ASPM field enables L0s, or L0s and L1; 10 is reserved.
module plc_link_control
  import plc_pkg::*;
#(
  parameter bit CLOCK_PM_CAPABLE = 1'b1,
  parameter int NFTS_WIDTH = 8,
  parameter logic [2:0] L0S_LAT_COMMON = 3'h4,
  parameter logic [2:0] L0S_LAT_SEPARATE = 3'h4,
  parameter logic [7:0] NFTS_COMMON = 8'h10,
  parameter logic [7:0] NFTS_SEPARATE = 8'h10
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire plc_cfg_req_t cfg_req_i,
  output logic [15:0] cfg_rdata_o,
  output logic cfg_ack_o,
  input wire logic clk_pm_wants_clkreq_i,
  output logic clkreq_o,
  output plc_ctrl_t ctrl_o,
  output logic [2:0] l0s_exit_latency_o,
  output logic [NFTS_WIDTH-1:0] nfts_o
);

  // ******************************************************************
  // Storage.
  // ******************************************************************
  logic clock_pm_enable;
  logic extended_sync;
  logic common_clock_config;
  logic link_disable;
  logic far_end_loopback;
  logic [1:0] aspm;
  logic retrain_req;
  logic hit;
  logic wr_lo;
  logic wr_hi;
  logic l0s_allowed;
  logic l1_allowed;
  logic [15:0] reg_value;
  logic [15:0] field_value;
  logic wr_hit;
  logic rd_hit;
  logic [1:0] lane_wr;
  logic retrain_write;
  logic link_disable_rise;
  logic [2:0] next_l0s_exit_latency;
  logic [NFTS_WIDTH-1:0] next_nfts;

  // ******************************************************************
  // Bits that hold state or a fixed value; all others read as zero.
  // ******************************************************************
  localparam logic [15:0] READ_MASK = 16'(
    (1 << PLC_BIT_CLOCK_PM_ENABLE) |
    (1 << PLC_BIT_EXTENDED_SYNC) |
    (1 << PLC_BIT_COMMON_CLOCK_CONFIG) |
    (1 << PLC_BIT_LINK_DISABLE) |
    (1 << PLC_BIT_READ_COMPLETION_BOUNDARY) |
    (1 << PLC_BIT_FAR_END_LOOPBACK) |
    (1 << PLC_ASPM_MSB) |
    (1 << PLC_ASPM_LSB));

  // ******************************************************************
  // Register access decode, one write strobe per byte lane.
  // ******************************************************************
  assign hit = (cfg_req_i.addr == PLC_LINK_CONTROL_OFFSET);
  assign wr_hit = cfg_req_i.wr & hit;
  assign rd_hit = cfg_req_i.rd & hit;

  for (genvar lane = 0; lane < $bits(lane_wr); lane++) begin : g_lane_wr
    assign lane_wr[lane] = wr_hit & cfg_req_i.be[lane];
  end

  assign wr_lo = lane_wr[0];
  assign wr_hi = lane_wr[1];

  // ******************************************************************
  // Low byte read-write fields.
  // ******************************************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      extended_sync <= PLC_LINK_CONTROL_RESET[PLC_BIT_EXTENDED_SYNC];
      common_clock_config <= PLC_LINK_CONTROL_RESET[PLC_BIT_COMMON_CLOCK_CONFIG];
      link_disable <= PLC_LINK_CONTROL_RESET[PLC_BIT_LINK_DISABLE];
      far_end_loopback <= PLC_LINK_CONTROL_RESET[PLC_BIT_FAR_END_LOOPBACK];
      aspm <= PLC_LINK_CONTROL_RESET[PLC_ASPM_MSB:PLC_ASPM_LSB];
    end else if (wr_lo) begin
      extended_sync <= cfg_req_i.wdata[PLC_BIT_EXTENDED_SYNC];
      common_clock_config <= cfg_req_i.wdata[PLC_BIT_COMMON_CLOCK_CONFIG];
      link_disable <= cfg_req_i.wdata[PLC_BIT_LINK_DISABLE];
      far_end_loopback <= cfg_req_i.wdata[PLC_BIT_FAR_END_LOOPBACK];
      aspm <= cfg_req_i.wdata[PLC_ASPM_MSB:PLC_ASPM_LSB];
    end
  end

  // ******************************************************************
  // Clock power management enable in the high byte.
  // ******************************************************************
  if (CLOCK_PM_CAPABLE) begin : g_cpm_stored
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        clock_pm_enable <= PLC_LINK_CONTROL_RESET[PLC_BIT_CLOCK_PM_ENABLE];
      end else if (wr_hi) begin
        clock_pm_enable <= cfg_req_i.wdata[PLC_BIT_CLOCK_PM_ENABLE];
      end
    end
  end else begin : g_cpm_fixed
    assign clock_pm_enable = 1'b0;
  end

  // ******************************************************************
  // Retrain pulse from a retrain write or a rising link disable write.
  // ******************************************************************
  assign retrain_write = wr_lo & cfg_req_i.wdata[PLC_BIT_RETRAIN_LINK];
  assign link_disable_rise = wr_lo & ~link_disable &
    cfg_req_i.wdata[PLC_BIT_LINK_DISABLE];

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      retrain_req <= 1'b0;
    end else begin
      retrain_req <= retrain_write | link_disable_rise;
    end
  end

  // ******************************************************************
  // Read path.
  // ******************************************************************
  always_comb begin
    field_value = '0;
    field_value[PLC_BIT_CLOCK_PM_ENABLE] = clock_pm_enable;
    field_value[PLC_BIT_EXTENDED_SYNC] = extended_sync;
    field_value[PLC_BIT_COMMON_CLOCK_CONFIG] = common_clock_config;
    field_value[PLC_BIT_RETRAIN_LINK] = 1'b0;
    field_value[PLC_BIT_LINK_DISABLE] = link_disable;
    field_value[PLC_BIT_READ_COMPLETION_BOUNDARY] = PLC_RCB_64_BYTE;
    field_value[PLC_BIT_FAR_END_LOOPBACK] = far_end_loopback;
    field_value[PLC_ASPM_MSB:PLC_ASPM_LSB] = aspm;
  end

  for (genvar b = 0; b < PLC_REG_WIDTH; b++) begin : g_read_bit
    assign reg_value[b] = READ_MASK[b] & field_value[b];
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_rdata_o <= 16'h0000;
      cfg_ack_o <= 1'b0;
    end else begin
      cfg_ack_o <= rd_hit | wr_hit;
      if (rd_hit) begin
        cfg_rdata_o <= reg_value;
      end else begin
        cfg_rdata_o <= 16'h0000;
      end
    end
  end

  // ******************************************************************
  // Link power management decode.
  // ******************************************************************
  plc_aspm_decode u_aspm (
    .aspm_i(aspm),
    .l0s_allowed_o(l0s_allowed),
    .l1_allowed_o(l1_allowed)
  );

  // ******************************************************************
  // Outputs to the training state machine and clock request pin.
  // ******************************************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clkreq_o <= 1'b0;
    end else begin
      clkreq_o <= clock_pm_enable & clk_pm_wants_clkreq_i;
    end
  end

  always_comb begin
    if (common_clock_config) begin
      next_l0s_exit_latency = L0S_LAT_COMMON;
      next_nfts = NFTS_WIDTH'(NFTS_COMMON);
    end else begin
      next_l0s_exit_latency = L0S_LAT_SEPARATE;
      next_nfts = NFTS_WIDTH'(NFTS_SEPARATE);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      l0s_exit_latency_o <= PLC_LAT_WIDTH_ZERO;
      nfts_o <= '0;
    end else begin
      l0s_exit_latency_o <= next_l0s_exit_latency;
      nfts_o <= next_nfts;
    end
  end

  always_comb begin
    ctrl_o.clock_pm_enable = clock_pm_enable;
    ctrl_o.extended_sync = extended_sync;
    ctrl_o.common_clock_config = common_clock_config;
    ctrl_o.retrain_req = retrain_req;
    ctrl_o.link_disable = link_disable;
    ctrl_o.far_end_loopback = far_end_loopback;
    ctrl_o.l0s_allowed = l0s_allowed;
    ctrl_o.l1_allowed = l1_allowed;
  end

endmodule

// ===== rtl/plc_pkg.sv
package plc_pkg;

  // ******************************************************************
  // Register map and field layout.
  // ******************************************************************
  localparam logic [11:0] PLC_LINK_CONTROL_OFFSET = 12'h0b0;
  localparam int PLC_REG_WIDTH = 16;
  localparam logic [15:0] PLC_LINK_CONTROL_RESET = 16'h0000;

  localparam int PLC_BIT_CLOCK_PM_ENABLE = 8;
  localparam int PLC_BIT_EXTENDED_SYNC = 7;
  localparam int PLC_BIT_COMMON_CLOCK_CONFIG = 6;
  localparam int PLC_BIT_RETRAIN_LINK = 5;
  localparam int PLC_BIT_LINK_DISABLE = 4;
  localparam int PLC_BIT_READ_COMPLETION_BOUNDARY = 3;
  localparam int PLC_BIT_FAR_END_LOOPBACK = 2;
  localparam int PLC_ASPM_MSB = 1;
  localparam int PLC_ASPM_LSB = 0;

  localparam logic PLC_RCB_64_BYTE = 1'b0;
  localparam logic [2:0] PLC_LAT_WIDTH_ZERO = 3'h0;

  // ******************************************************************
  // Active state power management encodings.
  // ******************************************************************
  typedef enum logic [1:0] {
    PLC_ASPM_DISABLED = 2'b00,
    PLC_ASPM_L0S = 2'b01,
    PLC_ASPM_RESERVED = 2'b10,
    PLC_ASPM_L0S_L1 = 2'b11
  } plc_aspm_t;

  // ******************************************************************
  // Register access request and control outputs.
  // ******************************************************************
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } plc_cfg_req_t;

  typedef struct packed {
    logic clock_pm_enable;
    logic extended_sync;
    logic common_clock_config;
    logic retrain_req;
    logic link_disable;
    logic far_end_loopback;
    logic l0s_allowed;
    logic l1_allowed;
  } plc_ctrl_t;

endpackage

// ===== test/plc_far_model.sv
`timescale 1ns/1ps
module plc_far_model
  import plc_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire plc_ctrl_t ctrl_i,
  output logic wants_o = 1'b0
);
  logic [3:0] lfsr = 4'h9;
  // The clock engine asks for the clock irregularly, never while the link is disabled.
  always @(negedge clk_i) begin
    lfsr <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
    wants_o <= arst_n_i & lfsr[0] & ~ctrl_i.link_disable;
  end
endmodule

// ===== test/plc_link_control_properties.sv
`timescale 1ns/1ps
module plc_link_control_chk
  import plc_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire plc_cfg_req_t cfg_req_i,
  input wire logic [15:0] cfg_rdata_o,
  input wire logic cfg_ack_o,
  input wire logic clk_pm_wants_clkreq_i,
  input wire logic clkreq_o,
  input wire plc_ctrl_t ctrl_o
);
  logic hit;
  logic wr0;
  assign hit = (cfg_req_i.rd | cfg_req_i.wr) && cfg_req_i.addr == PLC_LINK_CONTROL_OFFSET;
  assign wr0 = hit && cfg_req_i.wr && cfg_req_i.be[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  ack_on_hit_a: assert property (hit |=> cfg_ack_o) else $error("ack missing");
  no_stray_ack_a: assert property (!hit |=> !cfg_ack_o) else $error("stray ack");
  zero_bits_a: assert property (cfg_ack_o |-> (cfg_rdata_o & 16'hfe28) == 16'h0000)
    else $error("fixed bits not zero");
  clkreq_low_a: assert property (!ctrl_o.clock_pm_enable |=> !clkreq_o)
    else $error("clock request not low");
  clkreq_use_a: assert property (ctrl_o.clock_pm_enable && clk_pm_wants_clkreq_i |=> clkreq_o)
    else $error("clock request not given");
  retrain_wr_a: assert property (wr0 && cfg_req_i.wdata[5] |=> ctrl_o.retrain_req)
    else $error("retrain missing");
  ld_rise_a: assert property ($rose(ctrl_o.link_disable) |-> ctrl_o.retrain_req)
    else $error("no retrain on disable");
  low_byte_wr_a: assert property (wr0 |=> ctrl_o.link_disable == $past(cfg_req_i.wdata[4]) &&
    ctrl_o.extended_sync == $past(cfg_req_i.wdata[7])) else $error("low byte not stored");
  aspm_order_a: assert property (ctrl_o.l1_allowed |-> ctrl_o.l0s_allowed)
    else $error("l1 without l0s");
  cover property (wr0 && cfg_req_i.wdata[5]);
  cover property (ctrl_o.l1_allowed);
  cover property (clkreq_o);
endmodule
bind plc_link_control plc_link_control_chk chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .cfg_req_i(cfg_req_i), .cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o),
  .clk_pm_wants_clkreq_i(clk_pm_wants_clkreq_i), .clkreq_o(clkreq_o), .ctrl_o(ctrl_o));

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import plc_pkg::*;
;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  plc_cfg_req_t req = '0;
  logic [15:0] rdata;
  logic ack;
  logic wants;
  logic clkreq;
  plc_ctrl_t ctrl;
  logic [2:0] lat;
  logic [7:0] nfts;
  logic [15:0] rdata_fixed;
  logic clkreq_fixed;
  logic [15:0] model = 16'h0000;
  logic [31:0] r;
  integer seed = 93;
  integer bad_count = 0;
  integer tests_run = 0;
  integer cyc = 0;
  initial forever #25 clk_i = ~clk_i;
  plc_link_control #(.L0S_LAT_COMMON(3'h2), .L0S_LAT_SEPARATE(3'h5), .NFTS_COMMON(8'h20),
    .NFTS_SEPARATE(8'h40)) uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .cfg_req_i(req),
    .cfg_rdata_o(rdata), .cfg_ack_o(ack), .clk_pm_wants_clkreq_i(wants), .clkreq_o(clkreq),
    .ctrl_o(ctrl), .l0s_exit_latency_o(lat), .nfts_o(nfts));
  plc_link_control #(.CLOCK_PM_CAPABLE(1'b0)) uut_fixed (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .cfg_req_i(req), .cfg_rdata_o(rdata_fixed), .cfg_ack_o(), .clk_pm_wants_clkreq_i(wants),
    .clkreq_o(clkreq_fixed), .ctrl_o(), .l0s_exit_latency_o(), .nfts_o());
  plc_far_model far (.clk_i(clk_i), .arst_n_i(arst_n_i), .ctrl_i(ctrl), .wants_o(wants));
  // ******************************************************************
  // Checking helpers.
  // ******************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] after_wr(logic [15:0] o, logic [1:0] be, logic [15:0] w);
    if (be[0]) o[7:0] = w[7:0] & 8'hd7;
    if (be[1]) o[15:8] = w[15:8] & 8'h01;
    return o;
  endfunction
  function automatic logic [15:0] ctrl_word(plc_ctrl_t c);
    return {7'h00, c.clock_pm_enable, c.extended_sync, c.common_clock_config, 1'b0,
      c.link_disable, 1'b0, c.far_end_loopback, 2'b00};
  endfunction
  task automatic access(input logic wr, input logic [11:0] a, input logic [1:0] be,
    input logic [15:0] w);
    logic h;
    logic rt;
    h = a == PLC_LINK_CONTROL_OFFSET;
    rt = h & wr & be[0] & (w[5] | (w[4] & ~model[4]));
    @(negedge clk_i);
    req = '{rd: ~wr, wr: wr, addr: a, be: be, wdata: w};
    @(negedge clk_i);
    req = '0;
    chk({15'h0, ack}, {15'h0, h});
    if (!wr) chk(rdata, h ? model : 16'h0000);
    chk({15'h0, ctrl.retrain_req}, {15'h0, rt});
    chk({15'h0, clkreq}, {15'h0, model[8] & wants});
    chk({15'h0, clkreq_fixed}, 16'h0000);
    if (!wr) chk(rdata_fixed, h ? (model & 16'hfeff) : 16'h0000);
    if (h && wr) model = after_wr(model, be, w);
    chk(ctrl_word(ctrl), model & 16'h01d4);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      report_and_stop;
    end
  end
  // ******************************************************************
  // Main sequence.
  // ******************************************************************
  initial begin
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    arst_n_i = 1'b1;
    access(1'b0, 12'h0b0, 2'b11, 16'h0000);
    access(1'b1, 12'h0b0, 2'b11, 16'hffff);
    access(1'b0, 12'h0b0, 2'b11, 16'h0000);
    access(1'b1, 12'h0b0, 2'b01, 16'h0010);
    access(1'b1, 12'h0b0, 2'b01, 16'h0000);
    access(1'b1, 12'h0b0, 2'b01, 16'h0010);
    for (int i = 0; i < 8; i++) begin
      access(1'b1, 12'h0b0, 2'b01, {9'h000, i[2], 4'h0, i[1:0]});
      access(1'b0, 12'h0b0, 2'b11, 16'h0000);
      chk({14'h0, ctrl.l1_allowed, ctrl.l0s_allowed}, {14'h0, &i[1:0], i[0]});
      chk({13'h0, lat}, i[2] ? 16'h0002 : 16'h0005);
      chk({8'h0, nfts}, i[2] ? 16'h0020 : 16'h0040);
    end
    for (int i = 0; i < 80; i++) begin
      r = $random(seed);
      access(r[18], r[19] ? r[31:20] : 12'h0b0, r[17:16], r[15:0]);
    end
    @(negedge clk_i);
    arst_n_i = 1'b0;
    model = PLC_LINK_CONTROL_RESET;
    repeat (2) @(negedge clk_i);
    arst_n_i = 1'b1;
    access(1'b0, PLC_LINK_CONTROL_OFFSET, 2'b11, 16'h0000);
    report_and_stop;
  end
endmodule
